// *** design/plsc_pkg.sv ***
package plsc_pkg;
  localparam int unsigned N_IN   = 12;
  localparam int unsigned N_OUT  = 7;
  localparam logic [7:0]  FN_W   = 8'h08;
  // Input function codes
  localparam logic [7:0]  IFN_LOOP_EN   = 8'h0e;
  localparam logic [7:0]  IFN_INVERT    = 8'h40;
  localparam logic [7:0]  IFN_ICLEAR    = 8'h48;
  // Output function codes (positive logic; OFN_NEG_BASE is the offset to negative logic)
  localparam logic [7:0]  OFN_LOWER     = 8'h0e;
  localparam logic [7:0]  OFN_UPPER     = 8'h0f;
  localparam logic [7:0]  OFN_ROT       = 8'h10;
  localparam logic [7:0]  OFN_ACTIVE    = 8'h2f;
  localparam logic [7:0]  OFN_DEVLIM    = 8'h30;
  localparam logic [7:0]  OFN_SUSPEND   = 8'h46;
  localparam logic [7:0]  OFN_NEG_BASE  = 8'h64;
  // Loop modes
  localparam logic [7:0]  MODE_DEV_REV   = 8'h0a;
  localparam logic [7:0]  MODE_DEV_FWD   = 8'h0b;
  localparam logic [7:0]  MODE_MEAS_REV  = 8'h14;
  localparam logic [7:0]  MODE_MEAS_FWD  = 8'h15;
  localparam logic [7:0]  MODE_NDEV_REV  = 8'h32;
  localparam logic [7:0]  MODE_NDEV_FWD  = 8'h33;
  localparam logic [7:0]  MODE_NMEAS_REV = 8'h3c;
  localparam logic [7:0]  MODE_NMEAS_FWD = 8'h3d;
  localparam logic [7:0]  MODE_FREE_OFS  = 8'h64;
  // Values in tenths of a percent, ADC_FULL in ADC counts; 9999 disables
  localparam logic [15:0] VAL_NONE      = 16'h270f;
  localparam logic [15:0] PCT_FULL      = 16'h03e8;
  localparam logic [15:0] ADC_FULL      = 16'h0fff;
  // Analog input select groups
  localparam logic [7:0]  AIN_5V_MASK   = 8'h01;
  // One bit per select code: set where the bipolar input spans plus/minus 5 V
  localparam logic [31:0] AIN_BIP5_SET  = 32'h0002b0ac;
  localparam logic [4:0]  AIN_MA_A      = 5'h06;
  localparam logic [4:0]  AIN_MA_B      = 5'h07;
  localparam logic [4:0]  AIN_MA_C      = 5'h10;
  localparam logic [4:0]  AIN_MA_D      = 5'h11;
  localparam logic [1:0]  T2_4_20MA     = 2'h0;
  localparam logic [1:0]  T2_1_5V       = 2'h1;
  localparam logic [1:0]  T2_2_10V      = 2'h2;
  localparam logic [12:0] ADC_OFS_FIFTH = 13'h0333;
  localparam logic [12:0] ADC_SPAN_4_5  = 13'h0ccc;
  localparam logic [15:0] FLAGS_RST     = 16'h0000;
endpackage

// *** design/plsc_outmux.sv ***
`timescale 1ns/100ps
`default_nettype none
module plsc_outmux
  import plsc_pkg::*;
(
  input  wire logic [7:0] func_i,
  input  wire logic [5:0] flags_i,
  output logic            level_o
);
  logic [7:0] base;
  logic       sel;
  always_comb begin
    base = (func_i >= OFN_NEG_BASE) ? 8'(func_i - OFN_NEG_BASE) : func_i;
    unique case (base)
      OFN_UPPER:   sel = flags_i[0];
      OFN_LOWER:   sel = flags_i[1];
      OFN_ROT:     sel = flags_i[2];
      OFN_ACTIVE:  sel = flags_i[3];
      OFN_SUSPEND: sel = flags_i[4];
      OFN_DEVLIM:  sel = flags_i[5];
      default:     sel = 1'b0;
    endcase
    level_o = (func_i >= OFN_NEG_BASE) ? ~sel : sel; // see RULE19
  end
endmodule
`default_nettype wire

// *** design/plsc_top.sv ***
// What this block does
// RULE1: Loop enable asserted runs closed loop; otherwise plain open-loop operation.
// RULE2: Network or enable-free loop modes run the loop without the enable input.
// RULE3: Measured modes take set point from analog or parameter, feedback from terminal two.
// RULE4: Deviation modes take external deviation from the bipolar analog terminal.
// RULE5: Action invert input swaps forward and reverse action.
// RULE6: Integral clear input holds integral and differential terms cleared.
// RULE7: Input terminals map functions by code 14, 64, 72.
// RULE8: Set point scaled to 0..100 percent over 0-5 V, 0-10 V or 0-20 mA.
// RULE9: Set-point parameter 9999 selects analog set point, else parameter value.
// RULE10: Measured value scaled over 4-20 mA, 1-5 V or 2-10 V by select 0,1,2.
// RULE11: Deviation scaled to plus/minus 100 percent over 5 V or 10 V span.
// RULE12: Network modes 50/51 supply deviation; 60/61 supply set point and measured.
// RULE13: Upper-limit flag when measured above limit, measured/network modes, limit not 9999.
// RULE14: Lower-limit flag when measured below limit, same conditions.
// RULE15: Rotation output high for forward indication, low for reverse or stop.
// RULE16: Loop-active output high while closed loop is in effect.
// RULE17: Suspension flag while interruption is active and detect time not 9999; the code also requires loop_run.
// RULE18: Deviation-limit flag when absolute deviation exceeds limit not 9999.
// RULE19: Output codes 100 and above drive the selected function inverted.
// RULE20: Inputs synchronised; outputs registered once per control cycle.
`timescale 1ns/100ps
`default_nettype none
module plsc_top
  import plsc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic [N_IN-1:0]     in_pin_i,
  input  wire logic [N_IN*8-1:0]   input_function_select_i,
  input  wire logic [N_OUT*8-1:0]  output_function_select_i,
  input  wire logic [7:0]          loop_mode_select_i,
  input  wire logic [4:0]          analog_input_select_i,
  input  wire logic [1:0]          second_terminal_input_select_i,
  input  wire logic [15:0]         setpoint_value_i,
  input  wire logic [15:0]         upper_limit_value_i,
  input  wire logic [15:0]         lower_limit_value_i,
  input  wire logic [15:0]         deviation_limit_value_i,
  input  wire logic [15:0]         suspend_detect_time_i,
  input  wire logic [11:0]         adc_setpoint_i,
  input  wire logic [11:0]         adc_measured_i,
  input  wire logic [11:0]         adc_deviation_i,
  input  wire logic [15:0]         net_setpoint_i,
  input  wire logic [15:0]         net_measured_i,
  input  wire logic signed [15:0]  net_deviation_i,
  input  wire logic                suspend_active_i,
  input  wire logic                panel_forward_i,
  output logic                     loop_run_o,
  output logic                     reverse_action_o,
  output logic                     accum_clear_o,
  output logic [15:0]              setpoint_pct_o,
  output logic [15:0]              measured_pct_o,
  output logic signed [15:0]       deviation_pct_o,
  output logic [N_OUT-1:0]         out_pin_o
);
  logic [N_IN-1:0]  sync1_reg;
  logic [N_IN-1:0]  sync2_reg;
  logic [N_IN-1:0]  is_en;
  logic [N_IN-1:0]  is_inv;
  logic [N_IN-1:0]  is_clr;
  logic             loop_enable_input;
  logic             action_invert_input;
  logic             integral_clear_input;
  logic             mode_dev;
  logic             mode_meas;
  logic             mode_ndev;
  logic             mode_nmeas;
  logic             mode_free;
  logic             mode_fwd;
  logic             loop_run;
  logic [15:0]      sp_analog;
  logic [15:0]      sp_pct;
  logic [15:0]      pv_pct;
  logic signed [15:0] dev_pct;
  logic signed [15:0] dev_abs;
  logic [12:0]      pv_raw;
  logic [5:0]       flags;
  logic [N_OUT-1:0] pin_level;
  logic             upper_limit_flag;
  logic             lower_limit_flag;
  logic             deviation_limit_flag;
  logic [7:0]       base_mode;

  // Two-stage input synchroniser
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= in_pin_i;
      sync2_reg <= sync1_reg; // see RULE20
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      assign is_en[gi]  = sync2_reg[gi] && input_function_select_i[gi*8 +: 8] == IFN_LOOP_EN;
      assign is_inv[gi] = sync2_reg[gi] && input_function_select_i[gi*8 +: 8] == IFN_INVERT;
      assign is_clr[gi] = sync2_reg[gi] && input_function_select_i[gi*8 +: 8] == IFN_ICLEAR;
    end
  endgenerate
  assign loop_enable_input    = |is_en;  // see RULE7
  assign action_invert_input  = |is_inv; // see RULE7
  assign integral_clear_input = |is_clr; // see RULE7

  assign base_mode  = (loop_mode_select_i >= MODE_FREE_OFS) ?
                      8'(loop_mode_select_i - MODE_FREE_OFS) : loop_mode_select_i;
  assign mode_dev   = base_mode == MODE_DEV_REV || base_mode == MODE_DEV_FWD;
  assign mode_meas  = base_mode == MODE_MEAS_REV || base_mode == MODE_MEAS_FWD;
  assign mode_ndev  = loop_mode_select_i == MODE_NDEV_REV || loop_mode_select_i == MODE_NDEV_FWD;
  assign mode_nmeas = loop_mode_select_i == MODE_NMEAS_REV
                      || loop_mode_select_i == MODE_NMEAS_FWD;
  assign mode_free  = loop_mode_select_i >= MODE_FREE_OFS && (mode_dev || mode_meas);
  assign mode_fwd   = loop_mode_select_i[0];
  assign loop_run   = (mode_dev || mode_meas || mode_ndev || mode_nmeas)
                      && (loop_enable_input                          // see RULE1
                          || mode_ndev || mode_nmeas || mode_free);  // see RULE2

  // Analog scaling to tenths of a percent
  always_comb begin
    if (analog_input_select_i == AIN_MA_A || analog_input_select_i == AIN_MA_B
        || analog_input_select_i == AIN_MA_C || analog_input_select_i == AIN_MA_D) begin
      sp_analog = 16'((32'(adc_setpoint_i) * 32'(PCT_FULL)) / 32'(ADC_FULL)); // see RULE8
    end else if (analog_input_select_i[0] & AIN_5V_MASK[0]) begin
      sp_analog = 16'((32'(adc_setpoint_i) * 32'(PCT_FULL) * 2) / 32'(ADC_FULL)); // see RULE8
    end else begin
      sp_analog = 16'((32'(adc_setpoint_i) * 32'(PCT_FULL)) / 32'(ADC_FULL)); // see RULE8
    end
    if (sp_analog > PCT_FULL) begin
      sp_analog = PCT_FULL;
    end
  end

  always_comb begin
    unique case (second_terminal_input_select_i)
      T2_1_5V:  pv_raw = 13'({1'b0, adc_measured_i}) * 13'h2; // see RULE10
      default:  pv_raw = 13'({1'b0, adc_measured_i});         // see RULE10
    endcase
    if (pv_raw <= ADC_OFS_FIFTH) begin
      pv_pct = 16'h0000;
    end else begin
      pv_pct = 16'((32'(pv_raw - ADC_OFS_FIFTH) * 32'(PCT_FULL)) / 32'(ADC_SPAN_4_5));
    end
    if (pv_pct > PCT_FULL) begin
      pv_pct = PCT_FULL;
    end
    if (mode_nmeas) begin
      pv_pct = net_measured_i; // see RULE12
    end
  end

  always_comb begin
    sp_pct = (setpoint_value_i == VAL_NONE) ? sp_analog : setpoint_value_i; // see RULE9 RULE3
    if (mode_nmeas) begin
      sp_pct = net_setpoint_i; // see RULE12
    end
    if (mode_dev) begin
      // Bipolar: midscale is zero; 5 V span doubles the gain
      dev_pct = 16'(((32'(signed'({1'b0, adc_deviation_i})) - 32'sd2048)
                * 32'sd1000) / 32'sd2048); // see RULE4 RULE11
      if (AIN_BIP5_SET[analog_input_select_i]) begin
        dev_pct = 16'(32'(dev_pct) * 2); // see RULE11
      end
      if (dev_pct > 16'sd1000) dev_pct = 16'sd1000;
      if (dev_pct < -16'sd1000) dev_pct = -16'sd1000;
    end else if (mode_ndev) begin
      dev_pct = net_deviation_i; // see RULE12
    end else begin
      dev_pct = 16'(signed'(sp_pct) - signed'(pv_pct)); // see RULE3
    end
    dev_abs = dev_pct[15] ? 16'(-dev_pct) : dev_pct;
  end

  assign upper_limit_flag = (mode_meas || mode_nmeas) && upper_limit_value_i != VAL_NONE
                            && pv_pct > upper_limit_value_i; // see RULE13
  assign lower_limit_flag = (mode_meas || mode_nmeas) && lower_limit_value_i != VAL_NONE
                            && pv_pct < lower_limit_value_i; // see RULE14
  assign deviation_limit_flag = deviation_limit_value_i != VAL_NONE
                                && dev_abs > signed'(deviation_limit_value_i); // see RULE18
  assign flags = {deviation_limit_flag,
                  loop_run && suspend_active_i && suspend_detect_time_i != VAL_NONE, // see RULE17
                  loop_run,        // see RULE16
                  panel_forward_i, // see RULE15
                  lower_limit_flag,
                  upper_limit_flag};

  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_out
      plsc_outmux u_mux (
        .func_i  (output_function_select_i[gi*8 +: 8]),
        .flags_i (flags),
        .level_o (pin_level[gi])
      );
    end
  endgenerate

  // Registered loop control and values
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_run_o       <= 1'b0;
      reverse_action_o <= 1'b0;
      accum_clear_o    <= 1'b1;
    end else begin
      loop_run_o       <= loop_run;                          // see RULE1
      reverse_action_o <= ~mode_fwd ^ action_invert_input;   // see RULE5
      accum_clear_o    <= integral_clear_input || !loop_run; // see RULE6
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      setpoint_pct_o  <= '0;
      measured_pct_o  <= '0;
      deviation_pct_o <= '0;
    end else begin
      setpoint_pct_o  <= sp_pct;
      measured_pct_o  <= pv_pct;
      deviation_pct_o <= dev_pct;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_pin_o <= '0;
    end else begin
      out_pin_o <= pin_level; // see RULE20
    end
  end

  property p_loop_active;
    @(posedge clk_i) disable iff (!arst_n_i)
      loop_run |=> loop_run_o;
  endproperty
  a_loop_active: assert property (p_loop_active) else $error("loop not run"); // see RULE1

  property p_loop_idle;
    @(posedge clk_i) disable iff (!arst_n_i)
      !loop_run |=> !loop_run_o && accum_clear_o;
  endproperty
  a_loop_idle: assert property (p_loop_idle) else $error("loop ran while off"); // see RULE1

  property p_free_mode;
    @(posedge clk_i) disable iff (!arst_n_i)
      (mode_ndev || mode_nmeas || mode_free) |=> loop_run_o;
  endproperty
  a_free_mode: assert property (p_free_mode) else $error("network mode not run"); // see RULE2

  property p_clear;
    @(posedge clk_i) disable iff (!arst_n_i)
      integral_clear_input |=> accum_clear_o;
  endproperty
  a_clear: assert property (p_clear) else $error("accumulators not cleared"); // see RULE6

  property p_invert;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> reverse_action_o == ($past(~mode_fwd) ^ $past(action_invert_input));
  endproperty
  a_invert: assert property (p_invert) else $error("action direction wrong"); // see RULE5

  property p_upper;
    @(posedge clk_i) disable iff (!arst_n_i)
      upper_limit_value_i == VAL_NONE |-> !upper_limit_flag;
  endproperty
  a_upper: assert property (p_upper) else $error("upper flag while disabled"); // see RULE13

  property p_lower;
    @(posedge clk_i) disable iff (!arst_n_i)
      mode_dev |-> !lower_limit_flag;
  endproperty
  a_lower: assert property (p_lower) else $error("lower flag in deviation mode"); // see RULE14

  property p_suspend;
    @(posedge clk_i) disable iff (!arst_n_i)
      suspend_detect_time_i == VAL_NONE |-> !flags[4];
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspension while disabled"); // see RULE17

  property p_devlim;
    @(posedge clk_i) disable iff (!arst_n_i)
      deviation_limit_flag |-> dev_abs > signed'(deviation_limit_value_i);
  endproperty
  a_devlim: assert property (p_devlim) else $error("deviation flag wrong"); // see RULE18

  property p_meas_range;
    @(posedge clk_i) disable iff (!arst_n_i)
      !mode_nmeas |=> measured_pct_o <= PCT_FULL;
  endproperty
  a_meas_range: assert property (p_meas_range) else $error("measured above full"); // see RULE10

  property p_dev_range;
    @(posedge clk_i) disable iff (!arst_n_i)
      mode_dev |=> deviation_pct_o <= 16'sd1000 && deviation_pct_o >= -16'sd1000;
  endproperty
  a_dev_range: assert property (p_dev_range) else $error("deviation out of range"); // see RULE11

  sequence s_pin_moved;
    $changed(in_pin_i);
  endsequence

  sequence s_pin_landed;
    ##2 sync2_reg == $past(in_pin_i, 2);
  endsequence

  property p_sync;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_pin_moved |-> s_pin_landed;
  endproperty
  a_sync: assert property (p_sync) else $error("sync latency wrong"); // see RULE20
endmodule
`default_nettype wire

// *** verification/plsc_detector_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module plsc_detector_model
  import plsc_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic [15:0]        meas_pct_i,
  input  wire logic [15:0]        sp_pct_i,
  input  wire logic signed [15:0] dev_pct_i,
  output logic [11:0]             adc_measured_o,
  output logic [15:0]             net_setpoint_o,
  output logic [15:0]             net_measured_o,
  output logic signed [15:0]      net_deviation_o
);
  logic [31:0] code;
  // 4-20 mA detector: 20 % offset plus 80 % span
  assign code = 32'(ADC_OFS_FIFTH)
    + (32'(meas_pct_i) * 32'(ADC_SPAN_4_5)) / 32'(PCT_FULL);
  // Far side changes off the sampling edge
  always_ff @(negedge clk_i) begin
    adc_measured_o  <= code[11:0];
    net_setpoint_o  <= sp_pct_i;
    net_measured_o  <= meas_pct_i;
    net_deviation_o <= dev_pct_i;
  end
endmodule
`default_nettype wire

// *** verification/tb_process_loop_signal_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_process_loop_signal_control
  import plsc_pkg::*;
;
  logic               clk_i = 1'b0;
  logic               arst_n_i;
  logic [N_IN-1:0]    in_pin;
  logic [N_IN*8-1:0]  ifs;
  logic [N_OUT*8-1:0] ofs;
  logic [7:0]         mode;
  logic [4:0]         ain;
  logic [1:0]         t2sel;
  logic [15:0]        sp, ul, ll, dl, sdt, meas, net_sp_pct;
  logic signed [15:0] dev;
  logic [11:0]        adc_sp, adc_dev, adc_meas;
  logic [15:0]        net_sp, net_meas;
  logic signed [15:0] net_dev;
  logic               susp, fwd;
  logic               loop_run, rev_act, acc_clr;
  logic [15:0]        sp_pct, meas_pct;
  logic signed [15:0] dev_pct;
  logic [N_OUT-1:0]   out_pin;
  int                 n_mismatch = 0;
  int                 num_checks = 0;

  always #10 clk_i = ~clk_i;

  plsc_detector_model plsc_detector_model_i (
    .clk_i(clk_i), .meas_pct_i(meas), .sp_pct_i(net_sp_pct), .dev_pct_i(dev),
    .adc_measured_o(adc_meas), .net_setpoint_o(net_sp), .net_measured_o(net_meas),
    .net_deviation_o(net_dev));

  plsc_top plsc_top_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .in_pin_i(in_pin),
    .input_function_select_i(ifs), .output_function_select_i(ofs),
    .loop_mode_select_i(mode), .analog_input_select_i(ain),
    .second_terminal_input_select_i(t2sel), .setpoint_value_i(sp),
    .upper_limit_value_i(ul), .lower_limit_value_i(ll),
    .deviation_limit_value_i(dl), .suspend_detect_time_i(sdt),
    .adc_setpoint_i(adc_sp), .adc_measured_i(adc_meas), .adc_deviation_i(adc_dev),
    .net_setpoint_i(net_sp), .net_measured_i(net_meas), .net_deviation_i(net_dev),
    .suspend_active_i(susp), .panel_forward_i(fwd), .loop_run_o(loop_run),
    .reverse_action_o(rev_act), .accum_clear_o(acc_clr), .setpoint_pct_o(sp_pct),
    .measured_pct_o(meas_pct), .deviation_pct_o(dev_pct), .out_pin_o(out_pin));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Covers the two-stage pin synchroniser and output register plus slack
  task automatic step();
    repeat (4) @(negedge clk_i);
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200us;
    n_mismatch++;
    $display("Error at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
    wrap_up();
  end

  initial begin
    arst_n_i = 1'b0;
    in_pin = '0;
    ifs = '0;
    ifs[23:0] = {IFN_ICLEAR, IFN_INVERT, IFN_LOOP_EN};
    ofs = {8'h63, OFN_DEVLIM + OFN_NEG_BASE, OFN_SUSPEND, OFN_ACTIVE, OFN_ROT,
           OFN_LOWER + OFN_NEG_BASE, OFN_UPPER};
    mode = MODE_MEAS_REV;
    ain = 5'h00;
    t2sel = T2_4_20MA;
    {sp, ul, ll, dl, sdt} = {5{VAL_NONE}};
    meas = 16'h0000;
    net_sp_pct = 16'h0000;
    dev = 16'sh0000;
    adc_sp = 12'h000;
    adc_dev = 12'h800;
    susp = 1'b0;
    fwd = 1'b0;
    repeat (20) @(negedge clk_i);
    chk({15'h0, acc_clr}, 16'h0001);
    chk({9'h0, out_pin}, 16'h0000);
    chk({15'h0, loop_run}, 16'h0000);
    arst_n_i = 1'b1;
    step();
    $display("test reset done");
    chk({15'h0, loop_run}, 16'h0000);
    chk({15'h0, acc_clr}, 16'h0001);
    chk({9'h0, out_pin}, 16'h0022);
    in_pin[0] = 1'b1;
    step();
    chk({15'h0, loop_run}, 16'h0001);
    chk({15'h0, out_pin[3]}, 16'h0001);
    chk({15'h0, rev_act}, 16'h0001);
    chk({15'h0, acc_clr}, 16'h0000);
    $display("test enable done");
    in_pin[1] = 1'b1;
    step();
    chk({15'h0, rev_act}, 16'h0000);
    mode = MODE_MEAS_FWD;
    step();
    chk({15'h0, rev_act}, 16'h0001);
    in_pin[1] = 1'b0;
    in_pin[2] = 1'b1;
    step();
    chk({15'h0, rev_act}, 16'h0000);
    chk({15'h0, acc_clr}, 16'h0001);
    in_pin[2] = 1'b0;
    sp = 16'h01f4;
    meas = PCT_FULL;
    step();
    chk({15'h0, acc_clr}, 16'h0000);
    chk(sp_pct, 16'h01f4);
    chk(meas_pct, PCT_FULL);
    $display("test action done");
    sp = VAL_NONE;
    adc_sp = 12'hfff;
    meas = 16'h0000;
    step();
    chk(sp_pct, PCT_FULL);
    chk(meas_pct, 16'h0000);
    ain = 5'h01;
    step();
    chk(sp_pct, PCT_FULL);
    adc_sp = 12'h400;
    step();
    chk(sp_pct, 16'h01f4);
    ain = 5'h06;
    step();
    chk(sp_pct, 16'h00fa);
    adc_sp = 12'h000;
    mode = MODE_DEV_REV;
    step();
    chk(sp_pct, 16'h0000);
    chk(dev_pct, 16'h0000);
    adc_dev = 12'hc00;
    ain = 5'h05;
    step();
    chk(dev_pct, 16'h03e8);
    ain = 5'h0a;
    step();
    chk(dev_pct, 16'h01f4);
    adc_dev = 12'h800;
    mode = 8'h00;
    step();
    chk({15'h0, loop_run}, 16'h0000);
    $display("test scaling done");
    in_pin[0] = 1'b0;
    mode = MODE_NMEAS_REV;
    meas = 16'h0320;
    ul = 16'h02bc;
    ll = 16'h0064;
    step();
    chk({15'h0, loop_run}, 16'h0001);
    chk(meas_pct, 16'h0320);
    chk({14'h0, out_pin[1:0]}, 16'h0003);
    meas = 16'h0032;
    step();
    chk({14'h0, out_pin[1:0]}, 16'h0000);
    ll = VAL_NONE;
    step();
    chk({15'h0, out_pin[1]}, 16'h0001);
    mode = MODE_NDEV_FWD;
    dev = -16'sd600;
    dl = 16'h01f4;
    step();
    chk(dev_pct, 16'hfda8);
    chk({15'h0, out_pin[5]}, 16'h0000);
    dl = VAL_NONE;
    fwd = 1'b1;
    susp = 1'b1;
    sdt = 16'h000a;
    step();
    chk({15'h0, out_pin[5]}, 16'h0001);
    chk({13'h0, out_pin[6], out_pin[4], out_pin[2]}, 16'h0003);
    sdt = VAL_NONE;
    fwd = 1'b0;
    step();
    chk({14'h0, out_pin[4], out_pin[2]}, 16'h0000);
    mode = MODE_FREE_OFS + MODE_MEAS_REV;
    t2sel = T2_1_5V;
    meas = 16'h0000;
    ul = 16'h0064;
    step();
    chk({15'h0, loop_run}, 16'h0001);
    chk(meas_pct, 16'h00fa);
    chk({15'h0, out_pin[0]}, 16'h0001);
    chk({15'h0, rev_act}, 16'h0001);
    t2sel = T2_2_10V;
    step();
    chk(meas_pct, 16'h0000);
    chk({15'h0, out_pin[0]}, 16'h0000);
    $display("test flags done");
    wrap_up();
  end
endmodule
`default_nettype wire
